// *** verilog/tscr_cfg.svh ***
`ifndef TSCR_CFG_SVH
`define TSCR_CFG_SVH
// register byte offsets
`define TSCR_OFF_CTRL     8'h00
`define TSCR_OFF_XPT      8'h04
`define TSCR_OFF_DIVAB0   8'h08
`define TSCR_OFF_DIVAB1   8'h0C
`define TSCR_OFF_DIVCD    8'h10
`define TSCR_OFF_SYN2     8'h14
`define TSCR_OFF_SYN3     8'h18
`define TSCR_OFF_STBY     8'h1C
`define TSCR_OFF_SLOT     8'h20
`define TSCR_OFF_STAT     8'h24
`define TSCR_OFF_SYN1T    8'h40
`define TSCR_OFF_SYN1END  8'h5C
// field positions
`define TSCR_CTRL_FULLPD  0
`define TSCR_CTRL_STBYEN  1
`define TSCR_CTRL_CAP     2
`define TSCR_CTRL_BYPASS  8
`define TSCR_CTRL_DIV5    9
`define TSCR_CTRL_INV     11
`define TSCR_SYN_Q        0
`define TSCR_SYN_P        8
`define TSCR_STBY_OUT     3
// reset values
`define TSCR_RST_CTRL     32'h0000_0000
`define TSCR_RST_XPT      32'h0000_0000
`define TSCR_RST_DIV      32'h0000_0202
`define TSCR_RST_SYN      32'h0000_0101
`define TSCR_RST_STBY     32'h0000_0000
`define TSCR_RST_SLOT     32'h0000_0000
// bus answers
`define TSCR_RESP_OKAY    2'h0
`define TSCR_RESP_SLVERR  2'h2
// timing
`define TSCR_CLK_PERIOD_NS 100
`define TSCR_LOCK_TYP_US  1000
`define TSCR_LOCK_MAX_US  3000
`define TSCR_LOCK_CYC     ((`TSCR_LOCK_TYP_US * 1000 + `TSCR_CLK_PERIOD_NS - 1) / `TSCR_CLK_PERIOD_NS)
`endif

// *** verilog/tscr_pkg.sv ***
package tscr_pkg;
    // crosspoint source codes
    typedef enum logic [1:0] {
        TSCR_SRC_REF   = 2'h0,
        TSCR_SRC_ONE   = 2'h1,
        TSCR_SRC_TWO   = 2'h2,
        TSCR_SRC_THREE = 2'h3
    } tscr_src_t;
    // fifth output divide codes
    typedef enum logic [1:0] {
        TSCR_D5_BY2 = 2'h0,
        TSCR_D5_BY3 = 2'h1,
        TSCR_D5_BY4 = 2'h2
    } tscr_div5_t;
    typedef logic [6:0] tscr_div_t;
endpackage

// *** verilog/tscr_top.sv ***
`include "tscr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tscr_top
    import tscr_pkg::*;
#(
    parameter int LOCK_CYCLES = `TSCR_LOCK_CYC,
    parameter int ADDR_W      = 8
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // axi read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // control pins
    input  wire logic              freq_sel_bit0,
    input  wire logic              freq_sel_bit1,
    input  wire logic              freq_sel_bit2_or_standby_n,
    input  wire logic              pwr_down_oe_n,
    // clock outputs with enables
    output logic                   out_clk_first,
    output logic                   out_clk_first_oe,
    output logic                   out_clk_second,
    output logic                   out_clk_second_oe,
    output logic                   out_clk_third,
    output logic                   out_clk_third_oe,
    output logic                   out_clk_fourth,
    output logic                   out_clk_fourth_oe,
    output logic                   out_clk_fifth,
    output logic                   out_clk_fifth_oe,
    output logic                   ref_buffer_out,
    output logic                   ref_buffer_out_oe,
    // oscillator analog controls
    output logic [5:0]             osc_cap_load,
    output logic                   osc_cap_bypass,
    output logic                   osc_enable
);
    localparam int LCW = $clog2(LOCK_CYCLES + 1);
    localparam logic [LCW-1:0] LOCK_LAST = LCW'(LOCK_CYCLES);
    localparam logic [ADDR_W-1:0] A_CTRL = ADDR_W'(`TSCR_OFF_CTRL);
    localparam logic [ADDR_W-1:0] A_XPT = ADDR_W'(`TSCR_OFF_XPT);
    localparam logic [ADDR_W-1:0] A_DAB0 = ADDR_W'(`TSCR_OFF_DIVAB0);
    localparam logic [ADDR_W-1:0] A_DAB1 = ADDR_W'(`TSCR_OFF_DIVAB1);
    localparam logic [ADDR_W-1:0] A_DCD = ADDR_W'(`TSCR_OFF_DIVCD);
    localparam logic [ADDR_W-1:0] A_SYN2 = ADDR_W'(`TSCR_OFF_SYN2);
    localparam logic [ADDR_W-1:0] A_SYN3 = ADDR_W'(`TSCR_OFF_SYN3);
    localparam logic [ADDR_W-1:0] A_STBY = ADDR_W'(`TSCR_OFF_STBY);
    localparam logic [ADDR_W-1:0] A_SLOT = ADDR_W'(`TSCR_OFF_SLOT);
    localparam logic [ADDR_W-1:0] A_STAT = ADDR_W'(`TSCR_OFF_STAT);
    localparam logic [ADDR_W-1:0] A_T0 = ADDR_W'(`TSCR_OFF_SYN1T);
    localparam logic [ADDR_W-1:0] A_T7 = ADDR_W'(`TSCR_OFF_SYN1END);

    // byte-lane merge of a write
    function automatic logic [31:0] merge_w(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
        merge_w = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                merge_w[8*b +: 8] = d[8*b +: 8];
            end
        end
    endfunction

    // synth one table address check
    function automatic logic in_table(input logic [ADDR_W-1:0] a);
        return (a >= A_T0) && (a <= A_T7) && (a[1:0] == 2'h0);
    endfunction

    // address decode shared by both channels
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return in_table(a) || a == A_CTRL || a == A_XPT || a == A_DAB0 || a == A_DAB1 || a == A_DCD
            || a == A_SYN2 || a == A_SYN3 || a == A_STBY || a == A_SLOT || a == A_STAT;
    endfunction

    // zero divide value acts as one
    function automatic logic [6:0] eff_div(input logic [6:0] n);
        return (n == 7'h00) ? 7'h01 : n;
    endfunction

    // configuration registers
    logic [14:0] ctrl_q;
    logic [7:0]  xpt_q;
    logic [14:0] divab_q [2];
    logic [14:0] divcd_q;
    logic [18:0] syn_q [3];
    logic [18:0] syn1_tab_q [8];
    logic [8:0]  stby_q;
    logic [7:0]  slot_q;

    logic full_pd_en;
    logic stby_en;
    assign full_pd_en = ctrl_q[`TSCR_CTRL_FULLPD];
    assign stby_en    = ctrl_q[`TSCR_CTRL_STBYEN];
    assign osc_cap_load   = ctrl_q[`TSCR_CTRL_CAP +: 6];
    assign osc_cap_bypass = ctrl_q[`TSCR_CTRL_BYPASS];

    // pin synchronisers
    logic [2:0] sel_s1_q, sel_s2_q;
    logic       pdn_s1_q, pdn_s2_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_s1_q <= 3'h0;
            sel_s2_q <= 3'h0;
            pdn_s1_q <= 1'b0;
            pdn_s2_q <= 1'b0;
        end else begin
            sel_s1_q <= {freq_sel_bit2_or_standby_n, freq_sel_bit1, freq_sel_bit0};
            sel_s2_q <= sel_s1_q;
            pdn_s1_q <= pwr_down_oe_n;
            pdn_s2_q <= pdn_s1_q;
        end
    end

    // select code, standby and power-down state
    logic [2:0] code_q;
    logic       stby_act_q, pd_q, osc_run_q;
    logic       full_stop;
    assign full_stop = pd_q & full_pd_en;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            code_q     <= 3'h0;
            stby_act_q <= 1'b0;
            pd_q       <= 1'b1;
            osc_run_q  <= 1'b0;
        end else begin
            code_q     <= {sel_s2_q[2] & ~stby_en, sel_s2_q[1:0]};
            stby_act_q <= stby_en & ~sel_s2_q[2];
            pd_q       <= ~pdn_s2_q;
            osc_run_q  <= ~full_stop;
        end
    end
    assign osc_enable = osc_run_q;

    // per-synth P and Q; synth one indexed by select code
    logic [10:0] syn_p [3];
    logic [7:0]  syn_qd [3];
    assign syn_p[0]  = syn1_tab_q[code_q][`TSCR_SYN_P +: 11];
    assign syn_qd[0] = syn1_tab_q[code_q][`TSCR_SYN_Q +: 8];
    assign syn_p[1]  = syn_q[1][`TSCR_SYN_P +: 11];
    assign syn_qd[1] = syn_q[1][`TSCR_SYN_Q +: 8];
    assign syn_p[2]  = syn_q[2][`TSCR_SYN_P +: 11];
    assign syn_qd[2] = syn_q[2][`TSCR_SYN_Q +: 8];

    // synth models: tick rate ref*P/Q (capped at ref), lock timer
    logic [2:0] run, locked, syn_tick_q;
    generate
        for (genvar i = 0; i < 3; i++) begin : g_syn
            logic [7:0]     acc_q;
            logic [LCW-1:0] lcnt_q;
            logic [7:0]     q_eff;
            logic [11:0]    sum;
            logic           hit;
            logic           sat;
            assign run[i] = ~full_stop & ~(stby_act_q & stby_q[i]);
            assign q_eff  = (syn_qd[i] == 8'h00) ? 8'h01 : syn_qd[i];
            assign sum    = 12'(acc_q) + 12'(syn_p[i]);
            assign hit    = sum >= 12'(q_eff);
            assign sat    = 12'(syn_p[i]) >= 12'(q_eff);
            always_ff @(posedge aclk) begin
                if (!aresetn || !run[i]) begin
                    acc_q         <= 8'h00;
                    lcnt_q        <= '0;
                    locked[i]     <= 1'b0;
                    syn_tick_q[i] <= 1'b0;
                end else begin
                    acc_q         <= sat ? 8'h00 : (hit ? 8'(sum - 12'(q_eff)) : 8'(sum));
                    lcnt_q        <= (lcnt_q == LOCK_LAST) ? lcnt_q : lcnt_q + 1'b1;
                    locked[i]     <= locked[i] | (lcnt_q == LOCK_LAST);
                    syn_tick_q[i] <= locked[i] & hit;
                end
            end
        end
    endgenerate

    // divide values per output
    logic      slot_cur;
    tscr_div_t div_want [5];
    assign slot_cur    = slot_q[code_q];
    assign div_want[0] = slot_cur ? divab_q[1][6:0] : divab_q[0][6:0];
    assign div_want[1] = slot_cur ? divab_q[1][14:8] : divab_q[0][14:8];
    assign div_want[2] = divcd_q[6:0];
    assign div_want[3] = divcd_q[14:8];
    assign div_want[4] = (tscr_div5_t'(ctrl_q[`TSCR_CTRL_DIV5 +: 2]) == TSCR_D5_BY2) ? 7'h02 :
                         (tscr_div5_t'(ctrl_q[`TSCR_CTRL_DIV5 +: 2]) == TSCR_D5_BY3) ? 7'h03 : 7'h04;

    // post-dividers with enables; crosspoint source and phase inversion on the first four outputs only
    logic [4:0] src_tick, src_ok, load, lvl_q, oe_q;
    logic [6:0] cnt_q [5];
    logic [6:0] cur_q [5];
    generate
        for (genvar j = 0; j < 5; j++) begin : g_div
            logic [6:0] cur_eff;
            logic       inv;
            if (j < 4) begin : g_xpt
                tscr_src_t src;
                assign src = tscr_src_t'(xpt_q[2*j +: 2]);
                assign src_tick[j] = (src == TSCR_SRC_REF) ? ~full_stop : syn_tick_q[2'(src) - 2'h1];
                assign src_ok[j]   = (src == TSCR_SRC_REF) ? 1'b1 : locked[2'(src) - 2'h1];
                assign inv         = ctrl_q[`TSCR_CTRL_INV + j];
            end else begin : g_fifth
                assign src_tick[j] = syn_tick_q[0];
                assign src_ok[j]   = locked[0];
                assign inv         = 1'b0;
            end
            assign cur_eff = eff_div(cur_q[j]);
            assign load[j] = src_tick[j] & (cnt_q[j] >= cur_eff - 7'h01);
            always_ff @(posedge aclk) begin
                if (!aresetn || full_stop) begin
                    cnt_q[j] <= 7'h00;
                    cur_q[j] <= 7'h00;
                    lvl_q[j] <= 1'b0;
                end else begin
                    if (load[j]) begin
                        cnt_q[j] <= 7'h00;
                        cur_q[j] <= div_want[j];
                    end else if (src_tick[j]) begin
                        cnt_q[j] <= cnt_q[j] + 7'h01;
                    end
                    lvl_q[j] <= (cnt_q[j] < (cur_eff >> 1)) ^ inv;
                end
            end
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    oe_q[j] <= 1'b0;
                end else begin
                    oe_q[j] <= ~pd_q & ~(stby_act_q & stby_q[`TSCR_STBY_OUT + j]) & src_ok[j];
                end
            end
        end
    endgenerate

    // reference buffer enable
    logic ref_oe_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_oe_q <= 1'b0;
        end else begin
            ref_oe_q <= ~pd_q & ~(stby_act_q & stby_q[`TSCR_STBY_OUT + 5]);
        end
    end

    // pin drivers
    assign out_clk_first     = lvl_q[0];
    assign out_clk_second    = lvl_q[1];
    assign out_clk_third     = lvl_q[2];
    assign out_clk_fourth    = lvl_q[3];
    assign out_clk_fifth     = lvl_q[4];
    assign out_clk_first_oe  = oe_q[0];
    assign out_clk_second_oe = oe_q[1];
    assign out_clk_third_oe  = oe_q[2];
    assign out_clk_fourth_oe = oe_q[3];
    assign out_clk_fifth_oe  = oe_q[4];
    assign ref_buffer_out    = aclk & osc_run_q;
    assign ref_buffer_out_oe = ref_oe_q;

    // axi write channel
    logic              aw_have_q, w_have_q, bvalid_q, wr_go;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic [1:0]        bresp_q;
    assign s_axi_awready = ~aw_have_q & ~bvalid_q;
    assign s_axi_wready  = ~w_have_q & ~bvalid_q;
    assign wr_go         = aw_have_q & w_have_q & ~bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bresp_q   <= `TSCR_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= mapped(awaddr_q) ? `TSCR_RESP_OKAY : `TSCR_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // register writes
    logic [2:0] tidx_w;
    assign tidx_w = awaddr_q[4:2];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q     <= 15'(`TSCR_RST_CTRL);
            xpt_q      <= 8'(`TSCR_RST_XPT);
            divab_q[0] <= 15'(`TSCR_RST_DIV);
            divab_q[1] <= 15'(`TSCR_RST_DIV);
            divcd_q    <= 15'(`TSCR_RST_DIV);
            syn_q[0]   <= 19'(`TSCR_RST_SYN);
            syn_q[1]   <= 19'(`TSCR_RST_SYN);
            syn_q[2]   <= 19'(`TSCR_RST_SYN);
            stby_q     <= 9'(`TSCR_RST_STBY);
            slot_q     <= 8'(`TSCR_RST_SLOT);
            for (int k = 0; k < 8; k++) begin
                syn1_tab_q[k] <= 19'(`TSCR_RST_SYN);
            end
        end else if (wr_go) begin
            if (awaddr_q == A_CTRL) ctrl_q <= 15'(merge_w(32'(ctrl_q), wdata_q, wstrb_q));
            if (awaddr_q == A_XPT) xpt_q <= 8'(merge_w(32'(xpt_q), wdata_q, wstrb_q));
            if (awaddr_q == A_DAB0) divab_q[0] <= 15'(merge_w(32'(divab_q[0]), wdata_q, wstrb_q));
            if (awaddr_q == A_DAB1) divab_q[1] <= 15'(merge_w(32'(divab_q[1]), wdata_q, wstrb_q));
            if (awaddr_q == A_DCD) divcd_q <= 15'(merge_w(32'(divcd_q), wdata_q, wstrb_q));
            if (awaddr_q == A_SYN2) syn_q[1] <= 19'(merge_w(32'(syn_q[1]), wdata_q, wstrb_q));
            if (awaddr_q == A_SYN3) syn_q[2] <= 19'(merge_w(32'(syn_q[2]), wdata_q, wstrb_q));
            if (awaddr_q == A_STBY) stby_q <= 9'(merge_w(32'(stby_q), wdata_q, wstrb_q));
            if (awaddr_q == A_SLOT) slot_q <= 8'(merge_w(32'(slot_q), wdata_q, wstrb_q));
            if (in_table(awaddr_q)) begin
                syn1_tab_q[tidx_w] <= 19'(merge_w(32'(syn1_tab_q[tidx_w]), wdata_q, wstrb_q));
            end
        end
    end

    // read decode
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        if (in_table(s_axi_araddr)) rd_word = 32'(syn1_tab_q[s_axi_araddr[4:2]]);
        else if (s_axi_araddr == A_CTRL) rd_word = 32'(ctrl_q);
        else if (s_axi_araddr == A_XPT) rd_word = 32'(xpt_q);
        else if (s_axi_araddr == A_DAB0) rd_word = 32'(divab_q[0]);
        else if (s_axi_araddr == A_DAB1) rd_word = 32'(divab_q[1]);
        else if (s_axi_araddr == A_DCD) rd_word = 32'(divcd_q);
        else if (s_axi_araddr == A_SYN2) rd_word = 32'(syn_q[1]);
        else if (s_axi_araddr == A_SYN3) rd_word = 32'(syn_q[2]);
        else if (s_axi_araddr == A_STBY) rd_word = 32'(stby_q);
        else if (s_axi_araddr == A_SLOT) rd_word = 32'(slot_q);
        else if (s_axi_araddr == A_STAT) rd_word = {24'h000000, stby_act_q, pd_q, code_q, locked};
    end

    // axi read channel
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `TSCR_RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= mapped(s_axi_araddr) ? `TSCR_RESP_OKAY : `TSCR_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // checks
    logic [1:0] age_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) age_q <= 2'h0;
        else if (age_q != 2'h3) age_q <= age_q + 2'h1;
    end
    sequence s_pd_exit;
        full_pd_en && $fell(pd_q);
    endsequence
    a_relock_wait: assert property (@(posedge aclk) disable iff (!aresetn)
        s_pd_exit |-> !locked[0] [*8]) else $error("synth locked too soon after shutdown");
    a_pd_tristate: assert property (@(posedge aclk) disable iff (!aresetn)
        pd_q |=> (oe_q == 5'h00) && !ref_oe_q) else $error("output enabled during power-down");
    a_full_stop: assert property (@(posedge aclk) disable iff (!aresetn)
        full_stop |=> !osc_run_q && locked == 3'h0 && syn_tick_q == 3'h0) else $error("shutdown left logic running");
    a_chip_runs: assert property (@(posedge aclk) disable iff (!aresetn)
        pd_q && !full_pd_en |=> osc_run_q) else $error("oscillator stopped without full power-down");
    a_sel_sync: assert property (@(posedge aclk) disable iff (!aresetn)
        age_q == 2'h3 |-> code_q[0] == $past(freq_sel_bit0, 3)) else $error("select not three-stage delayed");
    a_div_boundary: assert property (@(posedge aclk) disable iff (!aresetn)
        !$stable(cur_q[0]) |-> $past(load[0]) || $past(full_stop)) else $error("divide changed mid-period");
    a_fifth_range: assert property (@(posedge aclk) disable iff (!aresetn)
        cur_q[4] != 7'h00 |-> cur_q[4] inside {7'h02, 7'h03, 7'h04}) else $error("fifth divide out of range");
    a_stby_out: assert property (@(posedge aclk) disable iff (!aresetn)
        stby_act_q && stby_q[`TSCR_STBY_OUT] |=> !oe_q[0]) else $error("standby output still driven");
    a_stby_synth: assert property (@(posedge aclk) disable iff (!aresetn)
        stby_act_q && stby_q[1] |=> !syn_tick_q[1] && !locked[1]) else $error("standby synth still running");
    a_same_slot: assert property (@(posedge aclk) disable iff (!aresetn)
        (div_want[0] == divab_q[1][6:0] && div_want[1] == divab_q[1][14:8])
        || (div_want[0] == divab_q[0][6:0] && div_want[1] == divab_q[0][14:8])) else $error("slots mixed");
    a_nco_full: assert property (@(posedge aclk) disable iff (!aresetn)
        locked[1] && run[1] && g_syn[1].sat |=> syn_tick_q[1] || !run[1]) else $error("synth rate below ref");
endmodule
`default_nettype wire

// *** tb/tscr_load.sv ***
`timescale 1ns/1ps
`default_nettype none
// board loads: a released pin drifts to the inverse of its last driven level
module tscr_load (
    // levels and enables from the block
    input  wire logic [5:0] lvl,
    input  wire logic [5:0] oe,
    // what the loads see
    output logic      [5:0] pin
);
    logic [5:0] last_q;
    // remember the last driven level of each pin
    always @(lvl or oe) for (int i = 0; i < 6; i++) if (oe[i]) last_q[i] = lvl[i];
    // a floating pin must not look like a held clock
    assign pin = (oe & lvl) | (~oe & ~last_q);
endmodule
`default_nettype wire

// *** tb/three_synth_clock_router_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tscr_cfg.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; $display("wrong value at %0t: %0h %0h", $time, a, e); end end
module three_synth_clock_router_tb;
    logic        aclk = 1'b0, aresetn = 1'b0, pwr_down_oe_n = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, osc_cap_bypass, osc_enable;
    logic        freq_sel_bit0 = 1'b0, freq_sel_bit1 = 1'b0, freq_sel_bit2_or_standby_n = 1'b0;
    logic        out_clk_first, out_clk_first_oe, out_clk_second, out_clk_second_oe, out_clk_third, out_clk_third_oe;
    logic        out_clk_fourth, out_clk_fourth_oe, out_clk_fifth, out_clk_fifth_oe, ref_buffer_out, ref_buffer_out_oe;
    logic [5:0]  osc_cap_load, pins;
    int          errors = 0, n_checks = 0;
    wire  [5:0]  oe = {ref_buffer_out_oe, out_clk_fifth_oe, out_clk_fourth_oe, out_clk_third_oe, out_clk_second_oe,
                       out_clk_first_oe};
    // reference clock, 100 ns period
    always #50 aclk = ~aclk;
    tscr_top #(.LOCK_CYCLES(16)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .freq_sel_bit0, .freq_sel_bit1, .freq_sel_bit2_or_standby_n, .pwr_down_oe_n, .out_clk_first,
        .out_clk_first_oe, .out_clk_second, .out_clk_second_oe, .out_clk_third, .out_clk_third_oe, .out_clk_fourth,
        .out_clk_fourth_oe, .out_clk_fifth, .out_clk_fifth_oe, .ref_buffer_out, .ref_buffer_out_oe, .osc_cap_load,
        .osc_cap_bypass, .osc_enable);
    tscr_load load_u (.lvl({ref_buffer_out, out_clk_fifth, out_clk_fourth, out_clk_third, out_clk_second,
        out_clk_first}), .oe(oe), .pin(pins));
    // verdict and end of run
    task automatic tally_and_finish(input bit hang);
        if (hang) errors++;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // one write, response compared
    task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int t;
        logic ta, tw, hb;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // handshakes are judged on values settled before the edge
        for (t = 0; t < 50; t++) begin
            #1;
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            hb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (hb) break;
        end
        if (t == 50) tally_and_finish(1'b1);
        `CHK(r, e)
        s_axi_bready <= 1'b0;
    endtask
    // one read, data and response compared
    task automatic rc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int t;
        logic ta, hr;
        logic [31:0] rd;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (t = 0; t < 50; t++) begin
            #1;
            ta = s_axi_arvalid && s_axi_arready;
            hr = s_axi_rvalid;
            rd = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (hr) break;
        end
        if (t == 50) tally_and_finish(1'b1);
        `CHK(rd, d)
        `CHK(r, e)
        s_axi_rready <= 1'b0;
    endtask
    // rising edges seen by a load over 120 reference cycles
    task automatic cnt(input int k, output int n);
        logic p;
        n = 0;
        p = pins[k];
        repeat (120) begin
            @(posedge aclk);
            #1;
            if (pins[k] && !p) n++;
            p = pins[k];
        end
    endtask
    // main sequence
    initial begin
        int n;
        int codes[3] = '{0, 1, 5};
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (8) @(posedge aclk);
        `CHK(out_clk_fifth_oe, 1'b0)
        rc(`TSCR_OFF_DIVCD, `TSCR_RST_DIV, `TSCR_RESP_OKAY);
        rc(`TSCR_OFF_SYN2, `TSCR_RST_SYN, `TSCR_RESP_OKAY);
        rc(8'h30, 32'h0, `TSCR_RESP_SLVERR);
        wc(8'h30, 32'h1, `TSCR_RESP_SLVERR);
        repeat (30) @(posedge aclk);
        `CHK(oe, 6'h3F)
        rc(`TSCR_OFF_STAT, 32'h07, `TSCR_RESP_OKAY);
        wc(`TSCR_OFF_CTRL, 32'h1A8, `TSCR_RESP_OKAY);
        `CHK(osc_cap_load, 6'h2A)
        `CHK(osc_cap_bypass, 1'b1)
        $display("test reset and lock done");
        for (int k = 0; k < 3; k++) begin
            wc(`TSCR_OFF_CTRL, k << `TSCR_CTRL_DIV5, `TSCR_RESP_OKAY);
            repeat (8) @(posedge aclk);
            cnt(4, n);
            `CHK(n, 120 / (k + 2))
        end
        $display("test fifth divider done");
        wc(`TSCR_OFF_DIVAB0, 32'h0204, `TSCR_RESP_OKAY);
        wc(`TSCR_OFF_DIVAB1, 32'h0206, `TSCR_RESP_OKAY);
        wc(`TSCR_OFF_SLOT, 32'h22, `TSCR_RESP_OKAY);
        foreach (codes[i]) begin
            @(posedge aclk);
            {freq_sel_bit2_or_standby_n, freq_sel_bit1, freq_sel_bit0} <= codes[i][2:0];
            repeat (12) @(posedge aclk);
            cnt(0, n);
            `CHK(n, ((32'h22 >> codes[i]) & 1) ? 20 : 30)
            rc(`TSCR_OFF_STAT, 32'h07 | (codes[i] << 3), `TSCR_RESP_OKAY);
        end
        $display("test select codes done");
        wc(`TSCR_OFF_STBY, 32'h8, `TSCR_RESP_OKAY);
        wc(`TSCR_OFF_CTRL, 32'h2, `TSCR_RESP_OKAY);
        @(posedge aclk);
        freq_sel_bit2_or_standby_n <= 1'b0;
        repeat (8) @(posedge aclk);
        `CHK(out_clk_first_oe, 1'b0)
        `CHK(out_clk_second_oe, 1'b1)
        rc(`TSCR_OFF_STAT, 32'h8F, `TSCR_RESP_OKAY);
        $display("test standby done");
        @(posedge aclk);
        pwr_down_oe_n <= 1'b0;
        repeat (8) @(posedge aclk);
        `CHK(oe, 6'h00)
        `CHK(osc_enable, 1'b1)
        wc(`TSCR_OFF_CTRL, 32'h1, `TSCR_RESP_OKAY);
        repeat (4) @(posedge aclk);
        `CHK(osc_enable, 1'b0)
        pwr_down_oe_n <= 1'b1;
        repeat (10) @(posedge aclk);
        `CHK(out_clk_fifth_oe, 1'b0)
        repeat (30) @(posedge aclk);
        `CHK(out_clk_fifth_oe, 1'b1)
        $display("test power down done");
        tally_and_finish(1'b0);
    end
endmodule
`default_nettype wire
